/* File: include/scp_defs.vh */
/*
  Constants for the serial configuration register port: frame widths,
  register count, default register values and link timing.
  Assumes a 250 MHz system clock and a slow link clock from the controller.
*/
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

`define SCP_ADDR_W      12
`define SCP_DATA_W      32
`define SCP_FRAME_W     44
`define SCP_NUM_REGS    8
`define SCP_IDX_W       3
`define SCP_SYNC_RST    2'h0
`define SCP_EDGE_RST    1'h0
`define SCP_OUT_FILL    1'h0
`define SCP_REQ_IDLE_N  1'h1
`define SCP_FRAME_ZERO  44'h000_0000_0000
`define SCP_DATA_ZERO   32'h0000_0000
`define SCP_LINK_HZ     500000
`define SCP_SYS_HZ      250000000

// default register contents restored by the defaults reset
`define SCP_DEF_REG0    32'h0000_0000
`define SCP_DEF_REG1    32'h0000_0000
`define SCP_DEF_REG2    32'h0000_0000
`define SCP_DEF_REG3    32'h0000_0000
`define SCP_DEF_REG4    32'h0000_0000
`define SCP_DEF_REG5    32'h0000_0000
`define SCP_DEF_REG6    32'h0000_0000
`define SCP_DEF_REG7    32'h0000_0000

`endif

/* File: core/scp_sync.v */
/*
  Two flip-flop level synchroniser, one bit.
  Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ns
`include "scp_defs.vh"
module scp_sync (
  // clock and reset
  input  wire clk_sys,
  input  wire reset,
  // level in and out
  input  wire d_async,
  output wire q_sync
);

  reg [1:0] sync_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      sync_reg <= `SCP_SYNC_RST;
    end else begin
      sync_reg <= {sync_reg[0], d_async};
    end
  end

  assign q_sync = sync_reg[1];

endmodule

/* File: core/scp_port.v */
/*
  Serial configuration register port: a slave that lets the board
  controller write and read a small bank of 32-bit registers over a
  slow serial link with a 12-bit address and 32-bit data phase.
  Assumes all link pins are asynchronous; they are synchronised to clk_sys
  and the link clock edges are detected in the clk_sys domain.
*/
`timescale 1ns/1ns
`include "scp_defs.vh"
module scp_port (
  // system clock and reset
  input  wire                     clk_sys,
  input  wire                     reset,
  // serial link from the controller
  input  wire                     cfg_serial_clock,
  input  wire                     cfg_defaults_reset_n,
  input  wire                     cfg_load_strobe,
  input  wire                     cfg_write_not_read,
  input  wire                     cfg_serial_in,
  output wire                     cfg_serial_out,
  // system reset request
  output wire                     soft_reset_request_n,
  // register contents for the fabric
  output wire [`SCP_NUM_REGS*`SCP_DATA_W-1:0] cfg_regs_flat
);

  ////////////////////////////////////////////////////////////////////////
  wire clk_s;
  wire rst_n_s;
  wire load_s;
  wire wnr_s;
  wire din_s;

  scp_sync u_sync_clk (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_async (cfg_serial_clock),
    .q_sync  (clk_s)
  );
  scp_sync u_sync_rst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_async (cfg_defaults_reset_n),
    .q_sync  (rst_n_s)
  );
  scp_sync u_sync_load (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_async (cfg_load_strobe),
    .q_sync  (load_s)
  );
  scp_sync u_sync_wnr (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_async (cfg_write_not_read),
    .q_sync  (wnr_s)
  );
  scp_sync u_sync_din (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_async (cfg_serial_in),
    .q_sync  (din_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised levels only
  reg clk_d_reg;
  reg load_d_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      clk_d_reg  <= `SCP_EDGE_RST;
      load_d_reg <= `SCP_EDGE_RST;
    end else begin
      clk_d_reg  <= clk_s;
      load_d_reg <= load_s;
    end
  end

  wire clk_rise  = clk_s & ~clk_d_reg;
  wire clk_fall  = ~clk_s & clk_d_reg;
  wire load_rise = load_s & ~load_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // input shifter: address then data, both msb first
  reg [`SCP_FRAME_W-1:0] shift_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      shift_reg <= `SCP_FRAME_ZERO;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[`SCP_FRAME_W-2:0], din_s};
    end
  end

  // for a write the address sits above the data word; for a read only
  // the address was shifted, so it lands in the low bits
  wire [`SCP_ADDR_W-1:0] wr_addr =
    shift_reg[`SCP_FRAME_W-1:`SCP_DATA_W];
  wire [`SCP_DATA_W-1:0] wr_data = shift_reg[`SCP_DATA_W-1:0];
  wire [`SCP_ADDR_W-1:0] rd_addr = shift_reg[`SCP_ADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // register bank; unmapped addresses drop writes and read as zero
  reg  [`SCP_DATA_W-1:0] bank_reg [0:`SCP_NUM_REGS-1];
  wire [`SCP_DATA_W*`SCP_NUM_REGS-1:0] defaults = {
    `SCP_DEF_REG7, `SCP_DEF_REG6, `SCP_DEF_REG5, `SCP_DEF_REG4,
    `SCP_DEF_REG3, `SCP_DEF_REG2, `SCP_DEF_REG1, `SCP_DEF_REG0};

  wire wr_hit = (wr_addr < `SCP_NUM_REGS);
  wire [`SCP_IDX_W-1:0] wr_idx = wr_addr[`SCP_IDX_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < `SCP_NUM_REGS; gi = gi + 1) begin : g_bank
      always @(posedge clk_sys) begin
        if (reset || !rst_n_s) begin
          bank_reg[gi] <= defaults[gi*`SCP_DATA_W +: `SCP_DATA_W];
        end else if (load_rise && wnr_s && wr_hit &&
                     wr_idx == gi) begin
          bank_reg[gi] <= wr_data;
        end
      end
      assign cfg_regs_flat[gi*`SCP_DATA_W +: `SCP_DATA_W] = bank_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read path: latch on load, shift out lsb first on falling link edges
  // so data is stable around the controller's sampling rising edge
  reg [`SCP_DATA_W-1:0] rd_shift_reg;
  wire rd_hit = (rd_addr < `SCP_NUM_REGS);
  wire [`SCP_IDX_W-1:0] rd_idx = rd_addr[`SCP_IDX_W-1:0];

  always @(posedge clk_sys) begin
    if (reset || !rst_n_s) begin
      rd_shift_reg <= `SCP_DATA_ZERO;
    end else if (load_rise && !wnr_s) begin
      rd_shift_reg <= rd_hit ? bank_reg[rd_idx] : `SCP_DATA_ZERO;
    end else if (clk_fall && !load_s) begin
      rd_shift_reg <= {`SCP_OUT_FILL, rd_shift_reg[`SCP_DATA_W-1:1]};
    end
  end

  // idles low after reset, defaults reset and a finished read
  assign cfg_serial_out = rd_shift_reg[0];

  // this slave never asks for a system reset
  assign soft_reset_request_n = `SCP_REQ_IDLE_N;

endmodule

/* File: testbench/scp_port_assertions.sv */
/* checker of the scp_port pins; bound to every scp_port below */
`timescale 1ns/1ns
module scp_port_chk (
  input wire         clk_sys, reset,
  input wire         cfg_serial_clock, cfg_defaults_reset_n,
  input wire         cfg_load_strobe, cfg_write_not_read,
  input wire         cfg_serial_out, soft_reset_request_n,
  input wire [255:0] cfg_regs_flat
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // defaults pin held long enough to pass the synchroniser
  sequence dflt_low_s;
    !cfg_defaults_reset_n [*4];
  endsequence
  // load strobe standing well past its latch point
  sequence load_held_s;
    cfg_load_strobe [*7];
  endsequence
  rst_clear_a:
    assert property (disable iff (1'b0) reset |=> !cfg_regs_flat)
    else $error("reset");
  dflt_clear_a:
    assert property (dflt_low_s |=> !cfg_regs_flat
    && !cfg_serial_out) else $error("defaults");
  req_high_a:
    assert property (soft_reset_request_n) else $error("request");
  regs_cause_a:
    assert property ($changed(cfg_regs_flat) |-> $past(cfg_load_strobe)
    || $past(!cfg_defaults_reset_n)) else $error("regs");
  wr_only_a:
    assert property ($changed(cfg_regs_flat) && cfg_defaults_reset_n
    |-> $past(cfg_write_not_read)) else $error("wnr");
  out_cause_a:
    assert property ($changed(cfg_serial_out) |-> $past(!cfg_serial_clock)
    || $past(cfg_load_strobe | !cfg_defaults_reset_n)) else $error("out");
  out_hold_a:
    assert property (load_held_s |-> $stable(cfg_serial_out))
    else $error("hold");
  rd_keep_a:
    assert property ($rose(cfg_load_strobe) && !cfg_write_not_read |=>
    $stable(cfg_regs_flat) [*8]) else $error("read");
endmodule
bind scp_port scp_port_chk chk_u (.clk_sys, .reset, .cfg_serial_clock,
  .cfg_defaults_reset_n, .cfg_load_strobe, .cfg_write_not_read,
  .cfg_serial_out, .soft_reset_request_n, .cfg_regs_flat);

/* File: testbench/scp_ctl_model.sv */
/* link master model; times itself on falls of a 4 ns clk_sys */
`timescale 1ns/1ns
module scp_ctl_model (
  input wire clk_sys, cfg_serial_out,
  output reg cfg_serial_clock = 1'b0, cfg_load_strobe = 1'b0,
  output reg cfg_write_not_read = 1'b0, cfg_serial_in = 1'b0
);
  // half link period; the clock stands low between frames
  task half;
    repeat (6) @(negedge clk_sys);
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
    integer i;
    begin
      cfg_write_not_read = w;
      for (i = 43; i >= (w ? 0 : 32); i = i - 1) begin
        cfg_serial_in = i > 31 ? a[i-32] : d[i];
        half;
        cfg_serial_clock = 1'b1;
        half;
        cfg_serial_clock = 1'b0;
      end
      cfg_serial_in = ~cfg_serial_in;
      half;
      cfg_load_strobe = 1'b1;
      repeat (2) half;
      cfg_load_strobe = 1'b0;
      half;
      for (i = 0; i < 32 && !w; i = i + 1) begin
        cfg_serial_clock = 1'b1;
        q[i] = cfg_serial_out;
        half;
        cfg_serial_clock = 1'b0;
        half;
      end
    end
  endtask
  // read address phase and load only; the shift-out is left pending
  task rd_latch(input [11:0] a);
    integer i;
    begin
      cfg_write_not_read = 1'b0;
      for (i = 11; i >= 0; i = i - 1) begin
        cfg_serial_in = a[i];
        half;
        cfg_serial_clock = 1'b1;
        half;
        cfg_serial_clock = 1'b0;
      end
      half;
      cfg_load_strobe = 1'b1;
      repeat (2) half;
      cfg_load_strobe = 1'b0;
      half;
    end
  endtask
endmodule

/* File: testbench/tb_scp_port.sv */
/* bench for scp_port; the model drives the link except the defaults reset pin, the bench that pin and the rest */
`timescale 1ns/1ns
`include "scp_defs.vh"
module tb_scp_port;
  reg          clk_sys = 1'b0;
  reg          reset = 1'b1;
  reg          dflt_n = 1'b1;
  wire         lk, ld, wr, si, so, rq_n;
  wire [255:0] regs;
  reg  [31:0]  q;
  integer      err_count = 0;
  integer      check_count = 0;
  always #2 clk_sys = ~clk_sys;
  scp_port dut_u (.clk_sys, .reset, .cfg_serial_clock(lk),
    .cfg_defaults_reset_n(dflt_n), .cfg_load_strobe(ld),
    .cfg_write_not_read(wr), .cfg_serial_in(si), .cfg_serial_out(so),
    .soft_reset_request_n(rq_n), .cfg_regs_flat(regs));
  scp_ctl_model ctl_u (.clk_sys, .cfg_serial_out(so), .cfg_serial_in(si),
    .cfg_serial_clock(lk), .cfg_load_strobe(ld), .cfg_write_not_read(wr));
  task chk(input [255:0] g, input [255:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      if (g !== e) err_count = err_count + 1;
    end
  endtask
  task t_reset;
    begin
      chk(regs, {`SCP_DEF_REG7, `SCP_DEF_REG6, `SCP_DEF_REG5,
        `SCP_DEF_REG4, `SCP_DEF_REG3, `SCP_DEF_REG2, `SCP_DEF_REG1,
        `SCP_DEF_REG0});
      chk(so, 1'b0);
      chk(rq_n, 1'b1);
    end
  endtask
  // 12'h807 must not alias register 7
  task t_access;
    begin
      ctl_u.xfer(1'b1, 12'h007, 32'h8421_0f3c, q);
      ctl_u.xfer(1'b1, 12'h000, 32'h1e5a_c381, q);
      ctl_u.xfer(1'b1, 12'h807, 32'hffff_ffff, q);
      chk(regs, {32'h8421_0f3c, 192'h0, 32'h1e5a_c381});
      ctl_u.xfer(1'b0, 12'h807, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      ctl_u.xfer(1'b0, 12'h007, 32'h0000_0000, q);
      chk(q, 32'h8421_0f3c);
    end
  endtask
  // system reset in mid-run must drop the written values
  task t_sysrst;
    begin
      reset = 1'b1;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      repeat (3) @(negedge clk_sys);
      t_reset;
    end
  endtask
  // defaults reset must clear a written word and a pending read bit
  task t_dflt;
    begin
      ctl_u.xfer(1'b1, 12'h000, 32'h1e5a_c381, q);
      ctl_u.rd_latch(12'h000);
      chk(so, 1'b1);
      dflt_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      dflt_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_reset;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #40000;
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_reset;
    t_access;
    t_sysrst;
    t_dflt;
    test_done;
  end
endmodule
